/* File: rtl/mtsf_pkg.sv */
// Package for the transmit status flag block: register map, flag layout,
// pin bundle, states and timing constants.
// Assumes a 40 MHz core clock and an APB master with 32-bit data.
package mtsf_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFF_CFG      = 8'h00;
    localparam logic [7:0] OFF_START    = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h14;

    // Field positions
    localparam int CFG_FULL_DUPLEX = 0;
    localparam int CFG_RETRY_LSB   = 1;
    localparam int START_BIT       = 15;

    // Reset values
    localparam logic [2:0]  CFG_RESET   = 3'h0;
    localparam logic [3:0]  IRQ_RESET   = 4'h0;
    localparam logic [31:0] RDATA_NONE  = 32'h0000_0000;

    // Interrupt event bits
    localparam int IRQ_W      = 4;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_ABORT  = 1;
    localparam int IRQ_LATE   = 2;
    localparam int IRQ_EXCESS_DEFERRAL_FLAG  = 3;

    // Timing: bit-time windows, and the heartbeat window in core cycles
    localparam int EXCESS_DEFER_BITS = 24288;
    localparam int LATE_WINDOW_BITS  = 512;
    localparam int BITS_PER_TICK     = 4;
    localparam int COL_LIMIT_STEP    = 4;
    localparam int CORE_PERIOD_PS    = 25000;
    localparam int SQE_WINDOW_PS     = 6400000;
    localparam int SQE_WINDOW_CYC    = SQE_WINDOW_PS / CORE_PERIOD_PS;

    // Transmit status word, bit 15 first
    typedef struct packed {
        logic excess_deferral_flag;
        logic deferral_flag;
        logic single_collision_flag;
        logic multi_collision_flag;
        logic collision_limit_error;
        logic collision_seen_flag;
        logic carrier_loss_flag;
        logic aborted_flag;
        logic late_collision_flag;
        logic pause_frame_sent_flag;
        logic heartbeat_test_fail;
        logic tx_paused_flag;
        logic tag_type_b_match;
        logic tag_type_a_match;
        logic tx_all_ones_dest;
        logic tx_group_dest;
    } mtsf_status_t;

    // Media pins sampled from the PHY
    typedef struct packed {
        logic heartbeat_ignore_input;
        logic col;
        logic crs;
        logic tx_clk;
    } mtsf_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEFER,
        ST_SEND,
        ST_GAP
    } mtsf_state_t;

endpackage

/* File: rtl/mtsf_sync.sv */
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; no bus coherency across bits is implied.
`timescale 1ns/1ps
`default_nettype none

module mtsf_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta;

    generate
        if (W < 1) begin : g_bad_width
            $error("mtsf_sync width must be at least one");
        end
    endgenerate

    // First stage only feeds the second, keeping metastability contained
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/mtsf_top.sv */
// Transmit status flags of an Ethernet MAC, with the start control, the
// deferral/collision sequencer behind them, an APB slave and an interrupt.
// Assumes MII pins arrive asynchronously and the datapath shares CORE_CLK_I.
//
// Summary of operation
// - Excess-deferral flag bit 15 pulses after waiting over 24,288 bit times.
// - Deferral flag bit 14 sets when held off 1 to 24,288 bit times.
// - Single-collision flag bit 13 sets after exactly one collision.
// - Multi-collision flag bit 12 sets after two or more collisions.
// - Collision-limit flag bit 11 on retry-limit abort; collision flags stay valid.
// - Carrier-loss flag bit 9 when carrier drops while sending half duplex.
// - Aborted flag bit 8 sets when a transmission is abandoned.
// - Aborted flag clears before the next packet begins.
// - Late-collision flag bit 7 for collisions past 512 bit times.
// - Late window counts from the first preamble bit.
// - Pause-sent flag bit 6 when the last packet was a pause frame.
// - Heartbeat-fail flag bit 5 when no collision in 6.4 us of gap.
// - Heartbeat-fail held inactive while the ignore input is high.
// - Flags 15 to 4 update on the rising edge of the transmit clock; bits 3 to 0 are never driven and stay zero.
// - Start bit launches a transmission and self-clears when it ends.
// - Paused flag bit 4 follows the pause-blocked transmitter.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module mtsf_top #(
    parameter int EXCESS_DEFER_BITS = mtsf_pkg::EXCESS_DEFER_BITS,
    parameter int LATE_WINDOW_BITS  = mtsf_pkg::LATE_WINDOW_BITS,
    parameter int BITS_PER_TICK     = mtsf_pkg::BITS_PER_TICK
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // MII pins from the PHY
    input  wire logic        TX_CLK_I,
    input  wire logic        CRS_I,
    input  wire logic        COL_I,
    input  wire logic        HEARTBEAT_IGNORE_I,
    // Transmit datapath
    input  wire logic        TX_DONE_I,
    input  wire logic        TX_ABORT_I,
    input  wire logic        PAUSE_FRAME_I,
    input  wire logic        TX_PAUSED_I,
    output logic             TX_SEND_O,
    // Interrupt
    output logic             IRQ_O
);

    localparam int CNT_W = $clog2(EXCESS_DEFER_BITS + 2 * BITS_PER_TICK);
    localparam int GAP_W = $clog2(mtsf_pkg::SQE_WINDOW_CYC + 1);
    localparam logic [CNT_W-1:0] EXCESS_C = CNT_W'(EXCESS_DEFER_BITS);
    localparam logic [CNT_W-1:0] LATE_C   = CNT_W'(LATE_WINDOW_BITS);
    localparam logic [CNT_W-1:0] STEP_C   = CNT_W'(BITS_PER_TICK);
    localparam logic [GAP_W-1:0] SQE_C    = GAP_W'(mtsf_pkg::SQE_WINDOW_CYC);
    localparam logic [4:0]       LIM_STEP = 5'(mtsf_pkg::COL_LIMIT_STEP);

    generate
        if (BITS_PER_TICK < 1 || LATE_WINDOW_BITS < 1 || EXCESS_DEFER_BITS <= LATE_WINDOW_BITS) begin : g_bad
            $error("mtsf_top needs positive windows with deferral limit above late window");
        end
    endgenerate

    mtsf_pkg::mtsf_pins_t  pins_raw;
    mtsf_pkg::mtsf_pins_t  pins;
    mtsf_pkg::mtsf_state_t state;
    mtsf_pkg::mtsf_status_t flags;

    logic                 tx_clk_d;
    logic                 tick;
    logic                 col_d;
    logic                 col_edge;
    logic [CNT_W-1:0]     bits;
    logic [GAP_W-1:0]     gap_cnt;
    logic [4:0]           col_cnt;
    logic [4:0]           col_next;
    logic [4:0]           col_limit;
    logic                 gap_col_seen;
    logic                 done_pend;
    logic                 abort_pend;
    logic                 pause_pend;
    logic [2:0]           cfg;
    logic                 start_bit;
    logic [mtsf_pkg::IRQ_W-1:0] irq_stat;
    logic [mtsf_pkg::IRQ_W-1:0] irq_en;
    logic [mtsf_pkg::IRQ_W-1:0] events;
    logic                 t_start;
    logic                 t_excess_deferral_flag;
    logic                 t_send;
    logic                 t_col;
    logic                 t_limit;
    logic                 t_abort;
    logic                 t_done;
    logic                 t_gap_end;
    logic                 finish;
    logic                 wr_en;
    logic                 rd_setup;
    logic                 addr_hit;

    // Pins cross into the core domain through two flops each
    assign pins_raw.tx_clk                 = TX_CLK_I;
    assign pins_raw.crs                    = CRS_I;
    assign pins_raw.col                    = COL_I;
    assign pins_raw.heartbeat_ignore_input = HEARTBEAT_IGNORE_I;

    mtsf_sync #(
        .W($bits(mtsf_pkg::mtsf_pins_t))
    ) u_sync (
        .clk_i   (CORE_CLK_I),
        .reset_i (RESET_I),
        .async_i (pins_raw),
        .sync_o  (pins)
    );

    // Transmit clock rising edge, found on the synchronised copy
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            tx_clk_d <= 1'b0;
            col_d    <= 1'b0;
        end else begin
            tx_clk_d <= pins.tx_clk;
            if (tick) begin
                col_d <= pins.col;
            end
        end
    end

    assign tick     = pins.tx_clk & ~tx_clk_d;
    assign col_edge = pins.col & ~col_d;

    // Retry setting picks the collision limit in steps
    assign col_limit = (5'(cfg[mtsf_pkg::CFG_RETRY_LSB +: 2]) + 5'h01) * LIM_STEP;
    assign col_next  = col_cnt + 5'h01;

    // Decisions taken at each transmit clock edge
    assign t_start   = tick & (state == mtsf_pkg::ST_IDLE) & start_bit;
    assign t_excess_deferral_flag   = tick & (state == mtsf_pkg::ST_DEFER) & (bits > EXCESS_C);
    assign t_send    = tick & (state == mtsf_pkg::ST_DEFER) & ~t_excess_deferral_flag & ~pins.crs;
    assign t_col     = tick & (state == mtsf_pkg::ST_SEND) & col_edge;
    assign t_limit   = t_col & (col_next > col_limit);
    assign t_abort   = tick & (state == mtsf_pkg::ST_SEND) & ~t_col & abort_pend;
    assign t_done    = tick & (state == mtsf_pkg::ST_SEND) & ~t_col & ~abort_pend & done_pend;
    assign t_gap_end = tick & (state == mtsf_pkg::ST_GAP) & (gap_cnt >= SQE_C);
    assign finish    = t_excess_deferral_flag | t_limit | t_abort | t_gap_end;

    // Datapath pulses may fall between transmit edges, so hold them
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            done_pend  <= 1'b0;
            abort_pend <= 1'b0;
            pause_pend <= 1'b0;
        end else begin
            done_pend  <= TX_DONE_I | (done_pend & ~tick);
            abort_pend <= TX_ABORT_I | (abort_pend & ~tick);
            if (TX_DONE_I) begin
                pause_pend <= PAUSE_FRAME_I;
            end
        end
    end

    // Sequencer: wait for idle medium, send, then watch the gap
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            state <= mtsf_pkg::ST_IDLE;
            bits  <= '0;
        end else if (tick) begin
            case (state)
                mtsf_pkg::ST_IDLE: begin
                    if (t_start) begin
                        state <= mtsf_pkg::ST_DEFER;
                        bits  <= '0;
                    end
                end
                mtsf_pkg::ST_DEFER: begin
                    if (t_excess_deferral_flag) begin
                        state <= mtsf_pkg::ST_IDLE;
                    end else if (t_send) begin
                        state <= mtsf_pkg::ST_SEND;
                        bits  <= STEP_C;
                    end else begin
                        bits <= bits + STEP_C;
                    end
                end
                mtsf_pkg::ST_SEND: begin
                    if (t_limit || t_abort) begin
                        state <= mtsf_pkg::ST_IDLE;
                    end else if (t_col) begin
                        state <= mtsf_pkg::ST_DEFER;                        // Retry
                        bits  <= '0;
                    end else if (t_done) begin
                        state <= mtsf_pkg::ST_GAP;
                    end else if (bits <= LATE_C) begin
                        bits <= bits + STEP_C;                              // Saturates past window
                    end
                end
                mtsf_pkg::ST_GAP: begin
                    if (t_gap_end) begin
                        state <= mtsf_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= mtsf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Gap timer runs on core cycles, so the 6.4 us window is exact here
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            gap_cnt      <= '0;
            gap_col_seen <= 1'b0;
        end else if (state != mtsf_pkg::ST_GAP) begin
            gap_cnt      <= '0;
            gap_col_seen <= 1'b0;
        end else begin
            if (gap_cnt < SQE_C) begin
                gap_cnt <= gap_cnt + 1'b1;
                gap_col_seen <= gap_col_seen | pins.col;
            end
        end
    end

    // Collision count of the current packet
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            col_cnt <= '0;
        end else if (t_start) begin
            col_cnt <= '0;
        end else if (t_col) begin
            col_cnt <= col_next;
        end
    end

    // Status flags change only on transmit clock edges
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            flags <= '0;
        end else if (tick) begin
            flags.excess_deferral_flag <= t_excess_deferral_flag;
            flags.tx_paused_flag       <= TX_PAUSED_I;
            if (pins.heartbeat_ignore_input) begin
                flags.heartbeat_test_fail <= 1'b0;
            end
            if (t_start) begin
                flags.deferral_flag         <= 1'b0;
                flags.single_collision_flag <= 1'b0;
                flags.multi_collision_flag  <= 1'b0;
                flags.collision_limit_error <= 1'b0;
                flags.collision_seen_flag   <= 1'b0;
                flags.carrier_loss_flag     <= 1'b0;
                flags.late_collision_flag   <= 1'b0;
                flags.aborted_flag          <= 1'b0;
            end
            if (t_send && bits != '0) begin
                flags.deferral_flag <= 1'b1;
            end
            if (t_col) begin
                flags.collision_seen_flag   <= 1'b1;
                flags.single_collision_flag <= (col_next == 5'h01);
                flags.multi_collision_flag  <= (col_next > 5'h01);
                if (bits > LATE_C) begin
                    flags.late_collision_flag <= 1'b1;
                end
            end
            if (t_limit) begin
                flags.collision_limit_error <= 1'b1;
            end
            if (t_limit || t_abort || t_excess_deferral_flag) begin
                flags.aborted_flag <= 1'b1;
            end
            if (state == mtsf_pkg::ST_SEND && !pins.crs && !cfg[mtsf_pkg::CFG_FULL_DUPLEX]) begin
                flags.carrier_loss_flag <= 1'b1;
            end
            if (t_done) begin
                flags.pause_frame_sent_flag <= pause_pend;
            end
            if (t_gap_end) begin
                flags.heartbeat_test_fail <= ~gap_col_seen & ~pins.heartbeat_ignore_input;
            end
        end
    end

    assign TX_SEND_O = (state == mtsf_pkg::ST_SEND);

    // APB decode; zero wait states, so ready is constant
    assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign addr_hit = (PADDR_I == mtsf_pkg::OFF_CFG) | (PADDR_I == mtsf_pkg::OFF_START)
                    | (PADDR_I == mtsf_pkg::OFF_STATUS) | (PADDR_I == mtsf_pkg::OFF_IRQ_STAT)
                    | (PADDR_I == mtsf_pkg::OFF_IRQ_CLR) | (PADDR_I == mtsf_pkg::OFF_IRQ_EN);
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

    // Configuration and interrupt enable
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            cfg    <= mtsf_pkg::CFG_RESET;
            irq_en <= mtsf_pkg::IRQ_RESET;
        end else if (wr_en) begin
            if (PADDR_I == mtsf_pkg::OFF_CFG) begin
                cfg <= PWDATA_I[2:0];
            end
            if (PADDR_I == mtsf_pkg::OFF_IRQ_EN) begin
                irq_en <= PWDATA_I[mtsf_pkg::IRQ_W-1:0];
            end
        end
    end

    // Start bit: software sets, the sequencer clears at the end; set wins
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            start_bit <= 1'b0;
        end else if (wr_en && PADDR_I == mtsf_pkg::OFF_START && PWDATA_I[mtsf_pkg::START_BIT]) begin
            start_bit <= 1'b1;
        end else if (finish) begin
            start_bit <= 1'b0;
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    assign events[mtsf_pkg::IRQ_DONE]  = finish;
    assign events[mtsf_pkg::IRQ_ABORT] = t_limit | t_abort | t_excess_deferral_flag;
    assign events[mtsf_pkg::IRQ_LATE]  = t_col & (bits > LATE_C);
    assign events[mtsf_pkg::IRQ_EXCESS_DEFERRAL_FLAG] = t_excess_deferral_flag;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            irq_stat <= mtsf_pkg::IRQ_RESET;
        end else if (wr_en && PADDR_I == mtsf_pkg::OFF_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~PWDATA_I[mtsf_pkg::IRQ_W-1:0]) | events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    // Registered interrupt, one cycle behind the status bits
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat & irq_en);
        end
    end

    // Read data captured in the setup phase, valid in the access phase
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            PRDATA_O <= mtsf_pkg::RDATA_NONE;
        end else if (rd_setup) begin
            case (PADDR_I)
                mtsf_pkg::OFF_CFG:      PRDATA_O <= {29'h0000_0000, cfg};
                mtsf_pkg::OFF_START:    PRDATA_O <= {16'h0000, start_bit, 15'h0000};
                mtsf_pkg::OFF_STATUS:   PRDATA_O <= {16'h0000, flags};
                mtsf_pkg::OFF_IRQ_STAT: PRDATA_O <= {28'h000_0000, irq_stat};
                mtsf_pkg::OFF_IRQ_EN:   PRDATA_O <= {28'h000_0000, irq_en};
                default:                PRDATA_O <= mtsf_pkg::RDATA_NONE;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: sim/mtsf_checker.sv */
// Port-level checker for the transmit status block.
// Assumes one core clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module mtsf_checker (
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_I,
    // Bus
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // Link and datapath
    input wire logic        TX_CLK_I,
    input wire logic        CRS_I,
    input wire logic        COL_I,
    input wire logic        TX_DONE_I,
    input wire logic        TX_ABORT_I,
    input wire logic        TX_SEND_O,
    input wire logic        IRQ_O
);
    logic [4:0] evt_age;
    logic       wr;
    logic       bad_addr;

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    // Age of the last cause that may end a send, saturating
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || TX_DONE_I || TX_ABORT_I || COL_I) begin
            evt_age <= 5'h00;
        end else if (evt_age != 5'h1F) begin
            evt_age <= evt_age + 5'h01;
        end
    end

    // Bus decodes; anything past the last word or unaligned is unmapped
    assign wr       = PSEL_I && PENABLE_I && PWRITE_I;
    assign bad_addr = (PADDR_I > 8'h14) || (PADDR_I[1:0] != 2'h0);

    chk_send_on_tick: assert property (!$stable(TX_SEND_O) |-> $past(TX_CLK_I, 2))
        else $error("send strobe moved off a tick");
    chk_send_when_idle: assert property ($rose(TX_SEND_O) |-> !$past(CRS_I, 3))
        else $error("send began on a busy medium");
    chk_send_end_cause: assert property ($fell(TX_SEND_O) |-> evt_age < 5'h10)
        else $error("send ended without a cause");
    chk_irq_rise_cause: assert property ($rose(IRQ_O) |-> $past(TX_CLK_I, 3) || $past(wr, 2))
        else $error("interrupt rose without a tick or write");
    chk_irq_fall_cause: assert property ($fell(IRQ_O) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt fell without a write");
    chk_bus_error_map: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == bad_addr)
        else $error("error response does not match the map");
    chk_zero_wait: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("access phase not ready");
    chk_read_hold: assert property (!$past(PSEL_I && !PENABLE_I) |-> $stable(PRDATA_O))
        else $error("read data moved outside a setup");

    cov_send: cover property ($rose(TX_SEND_O));
    cov_irq: cover property ($rose(IRQ_O));
    cov_error: cover property (PSLVERR_O);
endmodule

bind mtsf_top mtsf_checker i_mtsf_checker (.CORE_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .TX_CLK_I, .CRS_I, .COL_I, .TX_DONE_I,
    .TX_ABORT_I, .TX_SEND_O, .IRQ_O);
`default_nettype wire

/* File: sim/mtsf_phy_model.sv */
// PHY stand-in: free transmit clock, carrier and collision lines.
// Assumes the bench commands busy medium, collisions and carrier drop.
`timescale 1ns/1ps
`default_nettype none

module mtsf_phy_model (
    // Commands
    input  wire logic busy_i,
    input  wire logic col_i,
    input  wire logic drop_i,
    input  wire logic sqe_i,
    // MAC side
    input  wire logic send_i,
    output logic      tx_clk_o,
    output logic      crs_o,
    output logic      col_o
);
    logic hb = 1'b0;

    // 5 MHz clock, phase offset from the core clock on purpose
    initial begin
        tx_clk_o = 1'b0;
        #37;
        forever #100 tx_clk_o = ~tx_clk_o;
    end

    // Heartbeat echo after our own frame; only used on collision-free runs
    always @(negedge send_i) begin
        if (sqe_i) begin
            repeat (3) @(posedge tx_clk_o);
            hb = 1'b1;
            repeat (3) @(posedge tx_clk_o);
            hb = 1'b0;
        end
    end

    // Carrier echoes our send unless a drop is ordered
    assign crs_o = busy_i | (send_i & ~drop_i);
    assign col_o = col_i | hb;
endmodule
`default_nettype wire

/* File: sim/test_mtsf_top.sv */
// Bench for the transmit status block: APB tasks, packet runs, verdict.
// Assumes the PHY model file and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module test_mtsf_top;
    localparam logic [7:0] SA = mtsf_pkg::OFF_START;
    localparam logic [7:0] ST = mtsf_pkg::OFF_STATUS;
    localparam logic [7:0] IS = mtsf_pkg::OFF_IRQ_STAT;
    localparam logic [7:0] IE = mtsf_pkg::OFF_IRQ_EN;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, txclk, crs, col, send, irq, err, exd;
    logic        busy = 0, colc = 0, drop = 0, sqe = 0, ign = 0;
    logic        done = 0, abrt = 0, pause = 0, paused = 0;
    int          bad_count = 0;
    int          checks = 0;

    always #12.5 clk = ~clk;

    // Short windows keep the run brief: 64 deferral bits, 32 late bits
    mtsf_top #(.EXCESS_DEFER_BITS(64), .LATE_WINDOW_BITS(32)) i_mtsf_top (
        .CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TX_CLK_I(txclk), .CRS_I(crs), .COL_I(col), .HEARTBEAT_IGNORE_I(ign),
        .TX_DONE_I(done), .TX_ABORT_I(abrt), .PAUSE_FRAME_I(pause), .TX_PAUSED_I(paused),
        .TX_SEND_O(send), .IRQ_O(irq));
    mtsf_phy_model i_mtsf_phy_model (.busy_i(busy), .col_i(colc), .drop_i(drop), .sqe_i(sqe),
        .send_i(send), .tx_clk_o(txclk), .crs_o(crs), .col_o(col));

    task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_send();
        while (send !== 1'b1) @(posedge clk);
    endtask

    // One packet: busy over dly*4 status reads, ncol collisions late ticks into the send,
    // then finish by done (0), datapath abort (1) or nothing (2)
    task automatic pkt(input int dly, input int ncol, input int late, input int fin);
        int k = 0;
        exd = 1'b0;
        busy <= (dly != 0);
        apb(1, SA, 32'h0000_8000);
        repeat (dly * 4) begin
            apb(0, ST, 32'h0);
            exd = exd | rv[15];
        end
        busy <= 1'b0;
        for (int c = 0; c < ncol; c++) begin
            wait_send();
            repeat (late * 8) @(posedge clk);
            colc <= 1'b1;
            repeat (16) @(posedge clk);
            colc <= 1'b0;
        end
        if (fin != 2) wait_send();
        done <= (fin == 0);
        abrt <= (fin == 1);
        @(posedge clk);
        done <= 1'b0;
        abrt <= 1'b0;
        rv = 32'h8000;
        while (rv[15] === 1'b1 && k < 200) begin
            apb(0, SA, 32'h0);
            k++;
        end
        cmp("start self clear", rv[15], 1'b0);
    endtask

    // Status under a mask, then interrupt status and line, then clear
    task automatic post(input string nm, input logic [15:0] e, input logic [15:0] m, input logic [3:0] ie);
        apb(0, ST, 32'h0);
        cmp(nm, rv & {16'h0, m}, {16'h0, e});
        apb(0, IS, 32'h0);
        cmp("irq status", rv, {28'h0, ie});
        cmp("irq line", irq, ie != 4'h0);
        apb(1, mtsf_pkg::OFF_IRQ_CLR, 32'hF);
        @(posedge clk);
        cmp("irq cleared", irq, 1'b0);
        $display("Test %s finished", nm);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1, ST, 32'hFFFF);
        apb(0, ST, 32'h0);
        cmp("status after reset", rv, 32'h0);
        apb(0, mtsf_pkg::OFF_CFG, 32'h0);
        cmp("config reset", rv, {29'h0, mtsf_pkg::CFG_RESET});
        apb(0, 8'h18, 32'h0);
        cmp("unmapped error", err, 1'b1);
        apb(1, IE, 32'hF);
        sqe <= 1'b1;
        pause <= 1'b1;
        pkt(0, 0, 0, 0);
        post("pause frame", 16'h0040, 16'hBFFF, 4'h1);
        sqe <= 1'b0;
        pause <= 1'b0;
        paused <= 1'b1;
        pkt(6, 0, 0, 0);
        post("deferral", 16'h4030, 16'hFFFF, 4'h1);
        paused <= 1'b0;
        ign <= 1'b1;
        pkt(0, 1, 1, 0);
        post("single collision", 16'h2400, 16'hBFFF, 4'h1);
        pkt(0, 2, 1, 0);
        post("multi collision", 16'h1400, 16'hBFFF, 4'h1);
        pkt(0, 1, 10, 0);
        post("late collision", 16'h2480, 16'hBFFF, 4'h5);
        pkt(0, 5, 1, 2);
        post("retry limit", 16'h1D00, 16'hBFFF, 4'h3);
        pkt(0, 0, 0, 1);
        post("abort", 16'h0100, 16'hBFFF, 4'h3);
        ign <= 1'b0;
        sqe <= 1'b1;
        drop <= 1'b1;
        pkt(0, 0, 0, 0);
        post("carrier loss", 16'h0200, 16'hBFFF, 4'h1);
        drop <= 1'b0;
        sqe <= 1'b0;
        pkt(20, 0, 0, 2);
        cmp("excess deferral pulse", exd, 1'b1);
        apb(0, IS, 32'h0);
        cmp("excess deferral event", rv[3], 1'b1);
        apb(1, IE, 32'h0);
        apb(1, mtsf_pkg::OFF_IRQ_CLR, 32'hF);
        sqe <= 1'b1;
        pkt(0, 0, 0, 0);
        apb(0, IS, 32'h0);
        cmp("masked event kept", rv, 32'h1);
        cmp("masked line low", irq, 1'b0);
        apb(1, IE, 32'hF);
        repeat (2) @(posedge clk);
        cmp("unmasked line high", irq, 1'b1);
        conclude();
    end

    // Watchdog: the whole run needs well under a millisecond
    initial begin
        #2000000;
        bad_count++;
        $display("Watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
